// >>> rtl/tdcrb_consts.svh
// Constants for the TDC status/control register bank: offsets, fields, resets.
// Assumes a 16-bit register port with byte offsets from the board base.
`ifndef TDCRB_CONSTS_SVH
`define TDCRB_CONSTS_SVH

`define TDCRB_OFS_STATUS      16'h1002
`define TDCRB_OFS_RELOC_HIGH  16'h1004
`define TDCRB_OFS_RELOC_LOW   16'h1006
`define TDCRB_OFS_RELOC_SEL   16'h1008
`define TDCRB_OFS_IRQ_LEVEL   16'h100A
`define TDCRB_OFS_IRQ_VECTOR  16'h100C
`define TDCRB_OFS_SLOT        16'h100E
`define TDCRB_OFS_BCAST_BASE  16'h1010
`define TDCRB_OFS_BCAST_CTRL  16'h1012
`define TDCRB_OFS_MOD_RESET   16'h1014
`define TDCRB_OFS_SOFT_CLEAR  16'h1016
`define TDCRB_OFS_EVT_RESET   16'h1018
`define TDCRB_OFS_SOFT_TRIG   16'h101A
`define TDCRB_OFS_TRIG_CNT_LO 16'h101C
`define TDCRB_OFS_TRIG_CNT_HI 16'h101E
`define TDCRB_OFS_EVT_STORED  16'h1020
`define TDCRB_OFS_NEAR_FULL   16'h1022

// Status word bit positions
`define TDCRB_ST_DATA_AVAIL   0
`define TDCRB_ST_NEAR_FULL    1
`define TDCRB_ST_FULL         2
`define TDCRB_ST_WINDOWED     3
`define TDCRB_ST_HDR_EN       4
`define TDCRB_ST_TERM_ON      5
`define TDCRB_ST_ERR_LSB      6
`define TDCRB_ST_BUS_FAULT    10
`define TDCRB_ST_PURGED       11
`define TDCRB_ST_RES_LSB      12
`define TDCRB_ST_PAIR         14
`define TDCRB_ST_TRIG_LOST    15

// Reset values and sizes
`define TDCRB_RST_IRQ_LEVEL   3'h0
`define TDCRB_RST_IRQ_VECTOR  8'hDD
`define TDCRB_RST_SLOT        5'h1F
`define TDCRB_RST_BCAST_BASE  8'hAA
`define TDCRB_RST_NEAR_FULL   16'h0040
`define TDCRB_BUF_WORDS       16'h8000
`define TDCRB_FULL_MARGIN     16'h0021
`define TDCRB_FULL_LEVEL      16'h7FDF
`define TDCRB_RES_800PS       2'h0
`define TDCRB_RES_200PS       2'h1
`define TDCRB_RES_100PS       2'h2

`endif

// >>> rtl/tdcrb_pkg.sv
// Types shared by the TDC register bank.
// Assumes tdcrb_consts.svh is available on the include path.
package tdcrb_pkg;

  // Register port request as one carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } tdcrb_req_t;

  // Live configuration and condition inputs from the core
  typedef struct packed {
    logic       windowed;
    logic       hdr_en;
    logic       pair_mode;
    logic [1:0] resolution;
    logic       term_on;
    logic [3:0] tdc_error;
  } tdcrb_cfg_t;

endpackage : tdcrb_pkg

// >>> rtl/tdcrb_regs.sv
// Status and control register bank of a multihit TDC board.
// Assumes a synchronous single-cycle register port and synchronous core events.
//
// Behaviour
// - Data-available when buffer holds data/complete event.
// - Near-full when word count reaches threshold.
// - Full at capacity minus 33 words.
// - Status shows mode, header enable, pair mode.
// - Two-bit resolution code 800/200/100 ps.
// - Termination status bit reflects inserted terminations.
// - One error bit per TDC chip.
// - Bus-fault flag, cleared by status read.
// - Purged when empty or chain share sent.
// - Trigger-lost flag, cleared by status read.
// - Two 8-bit relocation address registers.
// - Relocation select picks new base address.
// - Three-bit IRQ level, zero disables interrupts.
// - Vector byte driven in acknowledge cycle.
// - Five-bit slot address resets to ones.
// - Broadcast base byte resets to AA.
// - Any module-reset access pulses whole reset.
// - Soft clear: TDC clear, buffer, counter.
// - Event-reset write pulses TDC event reset.
// - Soft-trigger write acts like trigger input.
// - 32-bit trigger counter, windowed mode only.
// - Stored-event count readable, 16 bits.
// - Near-full threshold defaults 64, writable.
`timescale 1ns/100ps
`include "tdcrb_consts.svh"

module tdcrb_regs
  import tdcrb_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire tdcrb_req_t  req,
  input  wire tdcrb_cfg_t  cfg,
  input  wire logic [15:0] buf_words,
  input  wire logic        evt_written,
  input  wire logic        evt_read_done,
  input  wire logic        trig_in,
  input  wire logic        trig_dropped,
  input  wire logic        bus_fault_evt,
  input  wire logic        chain_active,
  input  wire logic        chain_sent_all,
  input  wire logic        chain_end_fault,
  input  wire logic        iack,
  input  wire logic [7:0]  switch_base,
  output logic [15:0]      rdata,
  output logic             rvalid,
  output logic [7:0]       reloc_addr_high,
  output logic [7:0]       reloc_addr_low,
  output logic             reloc_sel,
  output logic [7:0]       base_addr_sel,
  output logic [2:0]       irq_level,
  output logic [7:0]       vector_out,
  output logic             vector_oe_n,
  output logic [4:0]       slot_address,
  output logic [7:0]       broadcast_base_addr,
  output logic [15:0]      broadcast_chain_control,
  output logic [15:0]      near_full_level,
  output logic             module_reset_pulse,
  output logic             tdc_clear_pulse,
  output logic             buf_clear_pulse,
  output logic             tdc_global_reset_pulse,
  output logic             evt_reset_pulse,
  output logic             trigger_pulse,
  output logic             data_available_flag,
  output logic             buf_full,
  output logic [31:0]      trigger_count,
  output logic [15:0]      buffered_event_count
);

  // True when the request hits the given offset
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic [15:0] status_reg,   status_next;
  logic        fault_reg,    fault_next;
  logic        lost_reg,     lost_next;
  logic        purged_reg,   purged_next;
  logic        chain_done_reg, chain_done_next;
  logic [7:0]  rhi_reg,      rhi_next;
  logic [7:0]  rlo_reg,      rlo_next;
  logic        rsel_reg,     rsel_next;
  logic [7:0]  base_reg,     base_next;
  logic [2:0]  lvl_reg,      lvl_next;
  logic [7:0]  vec_reg,      vec_next;
  logic [7:0]  vout_reg,     vout_next;
  logic        voe_n_reg,    voe_n_next;
  logic [4:0]  slot_reg,     slot_next;
  logic [7:0]  bcast_reg,    bcast_next;
  logic [15:0] bctl_reg,     bctl_next;
  logic [15:0] nfl_reg,      nfl_next;
  logic [15:0] rdata_reg,    rdata_next;
  logic        rvalid_reg,   rvalid_next;
  logic        mrst_reg,     mrst_next;
  logic        clr_reg,      clr_next;
  logic        evr_reg,      evr_next;
  logic        trg_reg,      trg_next;
  logic        dav_reg,      dav_next;
  logic        full_reg,     full_next;
  logic [31:0] tcnt_reg,     tcnt_next;
  logic [15:0] ecnt_reg,     ecnt_next;

  logic        st_read;
  logic        sw_trig;
  logic        wipe;

  assign st_read = req.rd & hit(req.addr, `TDCRB_OFS_STATUS);
  assign sw_trig = req.wr & hit(req.addr, `TDCRB_OFS_SOFT_TRIG);
  // Module reset and soft clear both restart counters; strobe acts a cycle late
  assign wipe    = mrst_reg | clr_reg;

  // Status flags, sticky flags and live condition bits
  always_comb begin
    fault_next      = (fault_reg & ~st_read) | bus_fault_evt;
    lost_next       = (lost_reg & ~st_read) | trig_dropped;
    chain_done_next = chain_active & (chain_done_reg | chain_sent_all); // held for the chain
    if (buffered_event_count_zero_or_empty()) begin
      purged_next = 1'b1;
    end else begin
      purged_next = chain_done_next;
    end
    if (chain_end_fault) begin
      purged_next     = (buf_words == 16'h0000);
      chain_done_next = 1'b0;
    end
    if (cfg.windowed) begin
      dav_next = (ecnt_reg != 16'h0000);
    end else begin
      dav_next = (buf_words != 16'h0000);
    end
    full_next = (buf_words >= `TDCRB_FULL_LEVEL);
    status_next = 16'h0000;
    status_next[`TDCRB_ST_DATA_AVAIL] = dav_reg;
    status_next[`TDCRB_ST_NEAR_FULL]  = (buf_words >= nfl_reg);
    status_next[`TDCRB_ST_FULL]       = full_reg;
    status_next[`TDCRB_ST_WINDOWED]   = cfg.windowed;
    status_next[`TDCRB_ST_HDR_EN]     = cfg.hdr_en;
    status_next[`TDCRB_ST_TERM_ON]    = cfg.term_on;
    status_next[`TDCRB_ST_ERR_LSB +: 4] = cfg.tdc_error;
    status_next[`TDCRB_ST_BUS_FAULT]  = fault_reg;
    status_next[`TDCRB_ST_PURGED]     = purged_reg;
    status_next[`TDCRB_ST_RES_LSB +: 2] = cfg.resolution;
    status_next[`TDCRB_ST_PAIR]       = cfg.pair_mode;
    status_next[`TDCRB_ST_TRIG_LOST]  = lost_reg;
  end

  // Empty buffer means nothing left to hand over
  function automatic logic buffered_event_count_zero_or_empty();
    buffered_event_count_zero_or_empty = (buf_words == 16'h0000);
  endfunction : buffered_event_count_zero_or_empty

  // Writable configuration registers
  always_comb begin
    rhi_next   = rhi_reg;
    rlo_next   = rlo_reg;
    rsel_next  = rsel_reg;
    lvl_next   = lvl_reg;
    vec_next   = vec_reg;
    slot_next  = slot_reg;
    bcast_next = bcast_reg;
    bctl_next  = bctl_reg;
    nfl_next   = nfl_reg;
    if (req.wr) begin
      case (req.addr)
        `TDCRB_OFS_RELOC_HIGH: rhi_next   = req.wdata[7:0];
        `TDCRB_OFS_RELOC_LOW:  rlo_next   = req.wdata[7:0];
        `TDCRB_OFS_RELOC_SEL:  rsel_next  = req.wdata[0];
        `TDCRB_OFS_IRQ_LEVEL:  lvl_next   = req.wdata[2:0];
        `TDCRB_OFS_IRQ_VECTOR: vec_next   = req.wdata[7:0];
        `TDCRB_OFS_SLOT:       slot_next  = req.wdata[4:0];
        `TDCRB_OFS_BCAST_BASE: bcast_next = req.wdata[7:0];
        `TDCRB_OFS_BCAST_CTRL: bctl_next  = req.wdata;
        `TDCRB_OFS_NEAR_FULL:  nfl_next   = req.wdata;
        default: begin
        end
      endcase
    end
    // Old base stops decoding once relocation is selected
    base_next = rsel_next ? rhi_next : switch_base;
    // Vector only driven while the acknowledge lasts
    voe_n_next = ~iack;
    vout_next  = iack ? vec_reg : 8'h00;
  end

  // Action strobes: each one cycle long
  always_comb begin
    mrst_next = (req.wr | req.rd) & hit(req.addr, `TDCRB_OFS_MOD_RESET);
    clr_next  = req.wr & hit(req.addr, `TDCRB_OFS_SOFT_CLEAR);
    evr_next  = req.wr & hit(req.addr, `TDCRB_OFS_EVT_RESET);
    trg_next  = trig_in | sw_trig;
  end

  // Counters
  always_comb begin
    tcnt_next = tcnt_reg;
    if (trg_reg && cfg.windowed) begin
      tcnt_next = tcnt_reg + 32'h0000_0001;
    end
    ecnt_next = ecnt_reg;
    if (evt_written && !evt_read_done) begin
      ecnt_next = ecnt_reg + 16'h0001;
    end else if (!evt_written && evt_read_done && ecnt_reg != 16'h0000) begin
      ecnt_next = ecnt_reg - 16'h0001;
    end
    // Clear wins: the buffer is being emptied at the same time
    if (wipe) begin
      tcnt_next = 32'h0000_0000;
      ecnt_next = 16'h0000;
    end
  end

  // Read data mux, answered one cycle after the request
  always_comb begin
    rvalid_next = req.rd;
    rdata_next  = 16'h0000;
    if (req.rd) begin
      case (req.addr)
        `TDCRB_OFS_STATUS:      rdata_next = status_reg;
        `TDCRB_OFS_RELOC_HIGH:  rdata_next = {8'h00, rhi_reg};
        `TDCRB_OFS_RELOC_LOW:   rdata_next = {8'h00, rlo_reg};
        `TDCRB_OFS_IRQ_LEVEL:   rdata_next = {13'h0000, lvl_reg};
        `TDCRB_OFS_IRQ_VECTOR:  rdata_next = {8'h00, vec_reg};
        `TDCRB_OFS_SLOT:        rdata_next = {11'h000, slot_reg};
        `TDCRB_OFS_BCAST_BASE:  rdata_next = {8'h00, bcast_reg};
        `TDCRB_OFS_BCAST_CTRL:  rdata_next = bctl_reg;
        `TDCRB_OFS_TRIG_CNT_LO: rdata_next = tcnt_reg[15:0];
        `TDCRB_OFS_TRIG_CNT_HI: rdata_next = tcnt_reg[31:16];
        `TDCRB_OFS_EVT_STORED:  rdata_next = ecnt_reg;
        `TDCRB_OFS_NEAR_FULL:   rdata_next = nfl_reg;
        default:                rdata_next = 16'h0000;
      endcase
    end
  end

  // All state registers; module reset strobe also reloads config
  always_ff @(posedge clk_sys) begin
    if (reset || mrst_reg) begin
      status_reg     <= 16'h0000;
      fault_reg      <= 1'b0;
      lost_reg       <= 1'b0;
      purged_reg     <= 1'b1;
      chain_done_reg <= 1'b0;
      rhi_reg        <= 8'h00;
      rlo_reg        <= 8'h00;
      rsel_reg       <= 1'b0;
      base_reg       <= 8'h00;
      lvl_reg        <= `TDCRB_RST_IRQ_LEVEL;
      vec_reg        <= `TDCRB_RST_IRQ_VECTOR;
      vout_reg       <= 8'h00;
      voe_n_reg      <= 1'b1;
      slot_reg       <= `TDCRB_RST_SLOT;
      bcast_reg      <= `TDCRB_RST_BCAST_BASE;
      bctl_reg       <= 16'h0000;
      nfl_reg        <= `TDCRB_RST_NEAR_FULL;
      rdata_reg      <= 16'h0000;
      rvalid_reg     <= 1'b0;
      mrst_reg       <= 1'b0;
      clr_reg        <= 1'b0;
      evr_reg        <= 1'b0;
      trg_reg        <= 1'b0;
      dav_reg        <= 1'b0;
      full_reg       <= 1'b0;
      tcnt_reg       <= 32'h0000_0000;
      ecnt_reg       <= 16'h0000;
    end else begin
      status_reg     <= status_next;
      fault_reg      <= fault_next;
      lost_reg       <= lost_next;
      purged_reg     <= purged_next;
      chain_done_reg <= chain_done_next;
      rhi_reg        <= rhi_next;
      rlo_reg        <= rlo_next;
      rsel_reg       <= rsel_next;
      base_reg       <= base_next;
      lvl_reg        <= lvl_next;
      vec_reg        <= vec_next;
      vout_reg       <= vout_next;
      voe_n_reg      <= voe_n_next;
      slot_reg       <= slot_next;
      bcast_reg      <= bcast_next;
      bctl_reg       <= bctl_next;
      nfl_reg        <= nfl_next;
      rdata_reg      <= rdata_next;
      rvalid_reg     <= rvalid_next;
      mrst_reg       <= mrst_next;
      clr_reg        <= clr_next;
      evr_reg        <= evr_next;
      trg_reg        <= trg_next;
      dav_reg        <= dav_next;
      full_reg       <= full_next;
      tcnt_reg       <= tcnt_next;
      ecnt_reg       <= ecnt_next;
    end
  end

  // Outputs straight from flip-flops
  assign rdata                   = rdata_reg;
  assign rvalid                  = rvalid_reg;
  assign reloc_addr_high         = rhi_reg;
  assign reloc_addr_low          = rlo_reg;
  assign reloc_sel               = rsel_reg;
  assign base_addr_sel           = base_reg;
  assign irq_level               = lvl_reg;                     // zero means no interrupts
  assign vector_out              = vout_reg;
  assign vector_oe_n             = voe_n_reg;
  assign slot_address            = slot_reg;
  assign broadcast_base_addr     = bcast_reg;
  assign broadcast_chain_control = bctl_reg;
  assign near_full_level         = nfl_reg;
  assign module_reset_pulse      = mrst_reg;
  assign tdc_clear_pulse         = clr_reg;
  assign buf_clear_pulse         = clr_reg;
  assign tdc_global_reset_pulse  = clr_reg;
  assign evt_reset_pulse         = evr_reg;
  assign trigger_pulse           = trg_reg;
  assign data_available_flag     = dav_reg;
  assign buf_full                = full_reg;
  assign trigger_count           = tcnt_reg;
  assign buffered_event_count    = ecnt_reg;

endmodule : tdcrb_regs

// >>> tb/tdcrb_props.sv
// Port-level timing checker for the TDC register bank, one clock domain.
// Assumes it is bound into tdcrb_regs and sees that module's ports only.
`timescale 1ns/100ps
`include "tdcrb_consts.svh"
module tdcrb_props
  import tdcrb_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire tdcrb_req_t  req,
  input wire tdcrb_cfg_t  cfg,
  input wire logic [15:0] buf_words,
  input wire logic        iack,
  input wire logic [7:0]  vector_out,
  input wire logic        vector_oe_n,
  input wire logic [2:0]  irq_level,
  input wire logic [4:0]  slot_address,
  input wire logic [7:0]  broadcast_base_addr,
  input wire logic [15:0] near_full_level,
  input wire logic        module_reset_pulse,
  input wire logic        tdc_clear_pulse,
  input wire logic        buf_clear_pulse,
  input wire logic        tdc_global_reset_pulse,
  input wire logic        evt_reset_pulse,
  input wire logic        trigger_pulse,
  input wire logic        data_available_flag,
  input wire logic        buf_full,
  input wire logic [31:0] trigger_count
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Request shapes, strobe groups and the reset image
  sequence wr_s(logic [15:0] a);
    req.wr && req.addr == a;
  endsequence
  sequence pulses_s;
    tdc_clear_pulse && buf_clear_pulse && tdc_global_reset_pulse;
  endsequence
  sequence image_s;
    slot_address == `TDCRB_RST_SLOT && broadcast_base_addr == `TDCRB_RST_BCAST_BASE
      && near_full_level == `TDCRB_RST_NEAR_FULL && irq_level == `TDCRB_RST_IRQ_LEVEL;
  endsequence

  // Read or write alike reaches the module reset
  mod_reset_a: assert property ((req.rd || req.wr) && req.addr == `TDCRB_OFS_MOD_RESET
    |=> module_reset_pulse) else $error("module reset access gave no pulse");
  soft_clear_a: assert property (wr_s(`TDCRB_OFS_SOFT_CLEAR) |=> pulses_s ##1
    trigger_count == 32'h0000_0000) else $error("soft clear incomplete");
  evt_reset_a: assert property (wr_s(`TDCRB_OFS_EVT_RESET) |=> evt_reset_pulse)
    else $error("event reset write gave no pulse");
  soft_trig_a: assert property (wr_s(`TDCRB_OFS_SOFT_TRIG) |=> trigger_pulse)
    else $error("soft trigger write gave no pulse");
  // Clears win over a coincident trigger, so those cycles are left out
  trig_count_a: assert property (trigger_pulse && !tdc_clear_pulse &&
    !module_reset_pulse |=> trigger_count == $past(trigger_count) + $past(cfg.windowed))
    else $error("trigger count step wrong");
  irq_level_a: assert property (wr_s(`TDCRB_OFS_IRQ_LEVEL) |=>
    irq_level == $past(req.wdata[2:0])) else $error("irq level not the low three bits");
  vector_drive_a: assert property (vector_oe_n == !$past(iack) &&
    (!vector_oe_n || vector_out == 8'h00)) else $error("vector drive window wrong");
  // Three settled cycles cover the status pipeline lag
  full_flag_a: assert property ($stable(buf_words) [*3] |->
    buf_full == (buf_words >= `TDCRB_FULL_LEVEL)) else $error("full flag wrong");
  // Module reset empties the flag pipeline, so its cycles are left out
  avail_cont_a: assert property (($stable(buf_words) && !cfg.windowed &&
    !module_reset_pulse) [*3] |->
    data_available_flag == (buf_words != 16'h0000)) else $error("data flag wrong");
  reset_image_a: assert property ($past(reset) |-> image_s)
    else $error("reset image wrong");
  mod_image_a: assert property (module_reset_pulse |-> ##2 image_s)
    else $error("module reset image wrong");
endmodule : tdcrb_props

bind tdcrb_regs tdcrb_props tdcrb_props_i (.clk_sys, .reset, .req, .cfg, .buf_words, .iack,
  .vector_out, .vector_oe_n, .irq_level, .slot_address, .broadcast_base_addr,
  .near_full_level, .module_reset_pulse, .tdc_clear_pulse, .buf_clear_pulse,
  .tdc_global_reset_pulse, .evt_reset_pulse, .trigger_pulse, .data_available_flag,
  .buf_full, .trigger_count);

// >>> tb/tdcrb_host_model.sv
// Register port master standing in for the crate controller.
// Assumes the bank takes one request per clk_sys edge with no wait states.
`timescale 1ns/100ps
module tdcrb_host_model
  import tdcrb_pkg::*;
(
  input  wire logic clk_sys,
  output tdcrb_req_t req
);
  // Idle from time zero
  initial begin
    req = '0;
  end

  // One access per falling edge; calls may follow back to back
  task automatic access(input logic rd, input logic wr, input logic [15:0] a,
                        input logic [15:0] d);
    @(negedge clk_sys);
    req <= '{rd: rd, wr: wr, addr: a, wdata: d};
  endtask : access

  // Released bus flips every cycle so a stale address never decodes by luck
  task automatic rest(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      req <= '{rd: 1'b0, wr: 1'b0, addr: ~req.addr, wdata: ~req.wdata};
    end
  endtask : rest
endmodule : tdcrb_host_model

// >>> tb/tdcrb_regs_bench.sv
// Self-checking bench for the TDC register bank.
// Assumes the host model issues requests and the checker is bound in.
`timescale 1ns/100ps
module tdcrb_regs_bench;
  import tdcrb_pkg::*;
  logic        clk_sys, reset, evt_written, evt_read_done, trig_in, trig_dropped;
  logic        bus_fault_evt, chain_active, chain_sent_all, chain_end_fault, iack;
  logic        rvalid, reloc_sel, vector_oe_n, module_reset_pulse, tdc_clear_pulse;
  logic        buf_clear_pulse, tdc_global_reset_pulse, evt_reset_pulse, trigger_pulse;
  logic        data_available_flag, buf_full;
  logic [2:0]  irq_level;
  logic [4:0]  slot_address;
  logic [7:0]  switch_base, reloc_addr_high, reloc_addr_low, base_addr_sel, vector_out;
  logic [7:0]  broadcast_base_addr;
  logic [15:0] buf_words, rdata, broadcast_chain_control, near_full_level;
  logic [15:0] buffered_event_count;
  logic [31:0] trigger_count, r;
  integer      seed;
  tdcrb_req_t  req;
  tdcrb_cfg_t  cfg;
  int          fails, check_count;
  logic [15:0] expect_q[$];
  // Reset image; an unmapped and a write-only place read zero
  logic [15:0] rst_a[11] = '{16'h100A, 16'h100C, 16'h100E, 16'h1010, 16'h1022, 16'h101C,
                             16'h101E, 16'h1020, 16'h1002, 16'h1040, 16'h1018};
  logic [15:0] rst_e[11] = '{16'h0000, 16'h00DD, 16'h001F, 16'h00AA, 16'h0040, 16'h0000,
                             16'h0000, 16'h0000, 16'h0800, 16'h0000, 16'h0000};
  // Writable places and the bits each keeps
  logic [15:0] rw_a[8] = '{16'h1004, 16'h1006, 16'h100A, 16'h100C, 16'h100E, 16'h1010,
                           16'h1012, 16'h1022};
  logic [15:0] rw_m[8] = '{16'h00FF, 16'h00FF, 16'h0007, 16'h00FF, 16'h001F, 16'h00FF,
                           16'hFFFF, 16'hFFFF};
  // Occupancy edges around a 0x100 threshold and the full level
  logic [15:0] lv_w[5] = '{16'h0000, 16'h00FF, 16'h0100, 16'h7FDE, 16'h7FDF};
  logic [2:0]  lv_f[5] = '{3'h0, 3'h1, 3'h3, 3'h3, 3'h7};

  tdcrb_host_model tdcrb_host_model_i (.clk_sys, .req);
  tdcrb_regs tdcrb_regs_i (.clk_sys, .reset, .req, .cfg, .buf_words, .evt_written,
    .evt_read_done, .trig_in, .trig_dropped, .bus_fault_evt, .chain_active, .chain_sent_all,
    .chain_end_fault, .iack, .switch_base, .rdata, .rvalid, .reloc_addr_high,
    .reloc_addr_low, .reloc_sel, .base_addr_sel, .irq_level, .vector_out, .vector_oe_n,
    .slot_address, .broadcast_base_addr, .broadcast_chain_control, .near_full_level,
    .module_reset_pulse, .tdc_clear_pulse, .buf_clear_pulse, .tdc_global_reset_pulse,
    .evt_reset_pulse, .trigger_pulse, .data_available_flag, .buf_full, .trigger_count,
    .buffered_event_count);

  // Clock, 5 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Expected status image from the live configuration
  function automatic logic [15:0] stat(input logic [2:0] f, input logic bf, pg, tl);
    stat = {tl, cfg.pair_mode, cfg.resolution, pg, bf, cfg.tdc_error, cfg.term_on,
            cfg.hdr_en, cfg.windowed, f};
  endfunction : stat

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    tdcrb_host_model_i.access(1'b1, 1'b0, a, 16'h0000);
    expect_q.push_back(e);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    tdcrb_host_model_i.access(1'b0, 1'b1, a, d);
  endtask : wr

  task automatic rest(input int n);
    tdcrb_host_model_i.rest(n);
  endtask : rest

  task automatic tally_and_finish;
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  // Answers come back in issue order, so the oldest note is the one due
  always @(negedge clk_sys) begin
    if (rvalid === 1'b1) begin
      check(rdata, (expect_q.size() > 0) ? expect_q.pop_front() : 16'hXXXX);
    end
  end

  // Hang guard
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    seed = 32'h3150;
    fails = 0;
    check_count = 0;
    reset = 1'b1;
    cfg = '0;
    buf_words = 16'h0000;
    {evt_written, evt_read_done, trig_in, trig_dropped, bus_fault_evt} = 5'h00;
    {chain_active, chain_sent_all, chain_end_fault, iack} = 4'h0;
    r = $random(seed);
    switch_base = r[7:0];
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    foreach (rst_a[i]) rd(rst_a[i], rst_e[i]);
    foreach (rw_a[i]) begin
      r = $random(seed);
      wr(rw_a[i], r[15:0]);
      rd(rw_a[i], r[15:0] & rw_m[i]);
    end
    // Base decode moves to the relocation byte once selected
    wr(16'h1004, 16'h00C3);
    rest(3);
    check(base_addr_sel, switch_base);
    wr(16'h1008, 16'h0001);
    rest(3);
    check(base_addr_sel, 8'hC3);
    check({reloc_sel, reloc_addr_high}, 9'h1C3);
    // Vector drive in the acknowledge window only
    wr(16'h100C, 16'hA55C);
    iack = 1'b1;
    rest(2);
    check({vector_oe_n, vector_out}, 9'h05C);
    iack = 1'b0;
    rest(2);
    check({vector_oe_n, vector_out}, 9'h100);
    // Fixed threshold before the status reads that follow, so near-full never rides on a random value
    wr(16'h1022, 16'h0100);
    for (int k = 0; k < 3; k++) begin
      r = $random(seed);
      cfg = '{windowed: 1'b0, hdr_en: r[0], pair_mode: r[1], resolution: k[1:0],
              term_on: r[2], tdc_error: r[6:3]};
      rest(3);
      rd(16'h1002, stat(3'h0, 1'b0, 1'b1, 1'b0));
    end
    foreach (lv_w[i]) begin
      buf_words = lv_w[i];
      rest(3);
      rd(16'h1002, stat(lv_f[i], 1'b0, lv_w[i] == 16'h0000, 1'b0));
    end
    // Sticky faults read once, then gone
    buf_words = 16'h0010;
    {bus_fault_evt, trig_dropped} = 2'h3;
    rest(1);
    {bus_fault_evt, trig_dropped} = 2'h0;
    rest(3);
    rd(16'h1002, stat(3'h1, 1'b1, 1'b0, 1'b1));
    rest(3);
    rd(16'h1002, stat(3'h1, 1'b0, 1'b0, 1'b0));
    wr(16'h100E, 16'h0007);
    {chain_active, chain_sent_all} = 2'h3;
    rest(3);
    rd(16'h1002, stat(3'h1, 1'b0, 1'b1, 1'b0));
    {chain_active, chain_sent_all, chain_end_fault} = 3'h1;
    rest(1);
    chain_end_fault = 1'b0;
    rest(3);
    rd(16'h1002, stat(3'h1, 1'b0, 1'b0, 1'b0));
    // Windowed mode: events stored, triggers from both sources
    cfg.windowed = 1'b1;
    rest(3);
    check(data_available_flag, 1'b0);
    repeat (3) begin
      evt_written = 1'b1;
      rest(1);
      evt_written = 1'b0;
      rest(1);
    end
    evt_read_done = 1'b1;
    rest(1);
    evt_read_done = 1'b0;
    wr(16'h101A, 16'h0000);
    wr(16'h101A, 16'hFFFF);
    rest(1);
    trig_in = 1'b1;
    rest(1);
    trig_in = 1'b0;
    rest(3);
    check(buffered_event_count, 16'h0002);
    rd(16'h1020, 16'h0002);
    rd(16'h101C, 16'h0003);
    rd(16'h101E, 16'h0000);
    rd(16'h1002, stat(3'h1, 1'b0, 1'b0, 1'b0));
    cfg.windowed = 1'b0;
    rest(2);
    wr(16'h101A, 16'h0000);
    rest(3);
    rd(16'h101C, 16'h0003);
    wr(16'h1016, 16'h0000);
    rest(3);
    rd(16'h101C, 16'h0000);
    rd(16'h1020, 16'h0000);
    r = $random(seed);
    tdcrb_host_model_i.access(1'b0, 1'b1, 16'h1014, r[15:0]);
    rest(4);
    check({reloc_sel, reloc_addr_high, reloc_addr_low}, 17'h0_0000);
    check(broadcast_chain_control, 16'h0000);
    rd(16'h100E, 16'h001F);
    rd(16'h100C, 16'h00DD);
    for (int i = 0; i < 10 && expect_q.size() > 0; i++) @(posedge clk_sys);
    check(expect_q.size(), 32'h0000_0000);
    tally_and_finish();
  end
endmodule : tdcrb_regs_bench
